// ### src/frx_regs.sv
// APB register bank for flow refresh and extended configuration control
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module frx_regs
	import frx_pkg::*;
(
	// Clock and resets
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        pci_reset,
	input  wire logic        sw_reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [19:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Flow-control side
	input  wire logic        byte_tick,
	input  wire logic        pause_active,
	input  wire logic        pause_sent,
	output logic             refresh_req,
	// Nonvolatile load path
	input  wire logic        nvm_ctrl_load,
	input  wire logic        nvm_area_we,
	input  wire logic        nvm_vendor_we,
	input  wire logic        nvm_len_load,
	input  wire logic [7:0]  nvm_len,
	// Hardware bus request and physical-layer configuration
	input  wire logic        hw_bus_req,
	input  wire logic        phy_cfg_pending,
	output logic             ext_area_enable,
	output logic [11:0]      ext_area_ptr,
	output logic [7:0]       ext_area_len,
	output logic             vendor_load_go,
	output logic             phy_cfg_go,
	output logic [31:0]      phy_ctrl_bits
);

	// ***************************************************************
	// Storage
	// ***************************************************************
	logic [31:0] ctrl_reg;
	logic [31:0] size_reg;
	logic [31:0] phy_reg;
	logic [15:0] thresh_reg;
	logic        hw_req_s1_reg;
	logic        hw_req_reg;
	logic        vendor_go_reg;
	logic        cfg_go_reg;
	logic        wr_en;
	logic        rd_hit;
	logic        sema_clr;
	logic [15:0] shadow_count;

	// Mask-merge of a bus word into the writable bits of a register
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	// Address hit check shared by write and read paths
	function automatic logic hit(input logic [19:0] a);
		hit = (a == FRX_OFS_EXT_CTRL) || (a == FRX_OFS_EXT_SIZE) ||
			(a == FRX_OFS_PHY_CTRL) || (a == FRX_OFS_REFRESH);
	endfunction

	// ***************************************************************
	// Bus handshake
	// ***************************************************************
	// Zero-wait slave: every access completes in its first access cycle
	assign pready   = 1'b1;
	assign wr_en    = psel && penable && pwrite;
	assign rd_hit   = hit(paddr);
	assign pslverr  = psel && penable && !rd_hit;
	assign sema_clr = pci_reset || sw_reset;

	// Hardware request arrives from another domain: two-stage synchroniser
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hw_req_s1_reg <= 1'b0;
			hw_req_reg    <= 1'b0;
		end else begin
			hw_req_s1_reg <= hw_bus_req;
			hw_req_reg    <= hw_req_s1_reg;
		end
	end

	// ***************************************************************
	// Extended configuration control
	// ***************************************************************
	// Software writes win over a simultaneous load only for non-loaded bits
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg <= FRX_CTRL_RESET;
		end else begin
			if (wr_en && paddr == FRX_OFS_EXT_CTRL) begin
				ctrl_reg <= merge(ctrl_reg, pwdata, FRX_CTRL_RW_MASK);
				ctrl_reg[27:FRX_PTR_LSB] <= pwdata[27:FRX_PTR_LSB];
			end
			if (nvm_ctrl_load) begin
				ctrl_reg[FRX_BIT_AREA_WE]   <= nvm_area_we;
				ctrl_reg[FRX_BIT_VENDOR_WE] <= nvm_vendor_we;
			end
			// Semaphore drops on every reset source, bus write notwithstanding
			if (sema_clr) begin
				ctrl_reg[FRX_BIT_SEMA] <= 1'b0;
			end else if (wr_en && paddr == FRX_OFS_EXT_CTRL) begin
				ctrl_reg[FRX_BIT_SEMA] <= pwdata[FRX_BIT_SEMA];
			end
		end
	end

	// ***************************************************************
	// Extended configuration size
	// ***************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			size_reg <= FRX_SIZE_RESET;
		end else if (nvm_len_load) begin
			size_reg[23:FRX_LEN_LSB] <= nvm_len;
		end else if (wr_en && paddr == FRX_OFS_EXT_SIZE) begin
			size_reg <= merge(size_reg, pwdata, FRX_SIZE_RW_MASK);
		end
	end

	// ***************************************************************
	// Physical-layer control and refresh threshold
	// ***************************************************************
	// Only the power-good reset restores these; other resets leave them alone
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phy_reg <= FRX_PHY_RESET;
		end else if (wr_en && paddr == FRX_OFS_PHY_CTRL) begin
			phy_reg <= pwdata;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			thresh_reg <= FRX_THRESH_RESET;
		end else if (wr_en && paddr == FRX_OFS_REFRESH) begin
			thresh_reg <= pwdata[15:0];
		end
	end

	// ***************************************************************
	// Physical-layer configuration actions
	// ***************************************************************
	// One-cycle pulses; held off while the gate bit is set
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_go_reg    <= 1'b0;
			vendor_go_reg <= 1'b0;
		end else begin
			cfg_go_reg    <= phy_cfg_pending && !ctrl_reg[FRX_BIT_GATE] && !cfg_go_reg;
			vendor_go_reg <= phy_cfg_pending && !ctrl_reg[FRX_BIT_GATE] && !vendor_go_reg
				&& ctrl_reg[FRX_BIT_VENDOR_WE];
		end
	end

	assign phy_cfg_go      = cfg_go_reg;
	assign vendor_load_go  = vendor_go_reg;
	assign phy_ctrl_bits   = phy_reg;
	assign ext_area_enable = ctrl_reg[FRX_BIT_AREA_WE];
	assign ext_area_ptr    = ctrl_reg[27:FRX_PTR_LSB];
	assign ext_area_len    = ctrl_reg[FRX_BIT_AREA_WE] ? size_reg[23:FRX_LEN_LSB] : 8'h00;

	// ***************************************************************
	// Read mux
	// ***************************************************************
	// Combinational read; status bit 6 is live hardware state, never stored
	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			unique case (paddr)
				FRX_OFS_EXT_CTRL: begin
					prdata = ctrl_reg;
					prdata[FRX_BIT_HW_REQ] = hw_req_reg;
				end
				FRX_OFS_EXT_SIZE: prdata = size_reg & FRX_SIZE_RW_MASK;
				FRX_OFS_PHY_CTRL: prdata = phy_reg;
				FRX_OFS_REFRESH:  prdata = {16'h0000, thresh_reg};
				default:          prdata = 32'h0000_0000;
			endcase
		end
	end

	// ***************************************************************
	// Refresh timer
	// ***************************************************************
	frx_refresh_timer u_timer (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.byte_tick    (byte_tick),
		.pause_active (pause_active),
		.pause_sent   (pause_sent),
		.threshold    (thresh_reg),
		.refresh_req  (refresh_req),
		.shadow_count (shadow_count)
	);

endmodule

// ### common/frx_pkg.sv
// Package of register map, field layout and timing constants for the flow/extended config bank
//
// Overview of operation
// - Send another pause frame when shadow counter hits threshold and pressure persists.
// - Refresh counter advances once per slot time of 64 byte times.
// - Zero threshold disables refresh pause frames entirely.
// - Extended configuration area is used only while its write-enable bit 0 is set.
// - Vendor-bits write-enable bit 3 (default 1) triggers automatic vendor bit load.
// - Driver semaphore bit 5 is set by driver, cleared by every reset.
// - Read-only bit 6 reports hardware management bus request; writes ignored.
// - Bit 7 holds off power-up sequence, variant-code read and vendor load.
// - Pointer bits 27:16 give extended area base in words, reset 0x001.
// - Size register bits 23:16 hold extended area length, loaded from area word 2.
// - Physical-layer control register returns to defaults on LAN power-good reset.
package frx_pkg;

	// ***************************************************************
	// Register offsets (byte addresses)
	// ***************************************************************
	localparam logic [19:0] FRX_OFS_EXT_CTRL = 20'h00f00;
	localparam logic [19:0] FRX_OFS_EXT_SIZE = 20'h00f08;
	localparam logic [19:0] FRX_OFS_PHY_CTRL = 20'h00f10;
	localparam logic [19:0] FRX_OFS_REFRESH  = 20'h05f40;

	// ***************************************************************
	// Field positions and reset values
	// ***************************************************************
	localparam int FRX_BIT_AREA_WE   = 0;
	localparam int FRX_BIT_VENDOR_WE = 3;
	localparam int FRX_BIT_SEMA      = 5;
	localparam int FRX_BIT_HW_REQ    = 6;
	localparam int FRX_BIT_GATE      = 7;
	localparam int FRX_PTR_LSB       = 16;
	localparam int FRX_LEN_LSB       = 16;
	// Bits 31:28, 7, 3 and 2:0 are plain read/write; bit 5 has its own path
	localparam logic [31:0] FRX_CTRL_RW_MASK = 32'hf000_008f;
	localparam logic [31:0] FRX_CTRL_RESET   = 32'h0001_0008;
	localparam logic [11:0] FRX_PTR_RESET    = 12'h001;
	localparam logic [31:0] FRX_SIZE_RW_MASK = 32'h00ff_ffff;
	localparam logic [31:0] FRX_SIZE_RESET   = 32'h0000_0000;
	localparam logic [31:0] FRX_PHY_RESET    = 32'h0006_000c;
	localparam logic [15:0] FRX_THRESH_RESET = 16'h0000;

	// ***************************************************************
	// Timing: slot time counted in byte times
	// ***************************************************************
	localparam int FRX_SLOT_BYTES = 64;
	localparam logic [6:0] FRX_SLOT_LAST = 7'(FRX_SLOT_BYTES - 1);

endpackage

// ### src/frx_refresh_timer.sv
// Flow-control refresh timer: repeats pause frames while buffer pressure persists
`timescale 1ns/1ns
module frx_refresh_timer
	import frx_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Link timing and flow-control state
	input  wire logic        byte_tick,
	input  wire logic        pause_active,
	input  wire logic        pause_sent,
	input  wire logic [15:0] threshold,
	// Request and status
	output logic             refresh_req,
	output logic [15:0]      shadow_count
);

	logic [6:0]  byte_cnt_reg;
	logic [15:0] shadow_reg;
	logic        req_reg;
	logic        slot_tick;

	// One slot time every 64 byte times
	assign slot_tick = byte_tick && (byte_cnt_reg == FRX_SLOT_LAST);

	// Byte counter restarts with the frame so every interval is a full slot
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			byte_cnt_reg <= 7'h00;
		end else if (!pause_active || pause_sent) begin
			byte_cnt_reg <= 7'h00;
		end else if (byte_tick) begin
			byte_cnt_reg <= slot_tick ? 7'h00 : byte_cnt_reg + 7'h01;
		end
	end

	// Shadow counter: restart on each pause frame, idle when pressure ends
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shadow_reg <= 16'h0000;
		end else if (!pause_active || pause_sent) begin
			shadow_reg <= 16'h0000;
		end else if (slot_tick && shadow_reg != threshold) begin
			shadow_reg <= shadow_reg + 16'h0001;
		end
	end

	// Request stays up until the transmitter reports the frame out, pressure ends or the threshold is zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			req_reg <= 1'b0;
		end else if (!pause_active || pause_sent || threshold == 16'h0000) begin
			req_reg <= 1'b0;
		end else if (shadow_reg == threshold) begin
			req_reg <= 1'b1;
		end
	end

	assign refresh_req  = req_reg;
	assign shadow_count = shadow_reg;

endmodule

// ### bench/frx_regs_properties.sv
// Assertion checker bound to the flow refresh and extended config register bank
`timescale 1ns/1ns
module frx_regs_properties
	import frx_pkg::*;
(
	// Clock, reset and bus
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [19:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Block side
	input wire logic        pause_active,
	input wire logic        pause_sent,
	input wire logic        refresh_req,
	input wire logic        hw_bus_req,
	input wire logic        ext_area_enable,
	input wire logic [11:0] ext_area_ptr,
	input wire logic [7:0]  ext_area_len
);
	// ********
	// Sequences
	// ********
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_rd_ctrl;
		psel && penable && !pwrite && paddr == FRX_OFS_EXT_CTRL;
	endsequence
	// Request must be held through both synchroniser flops
	sequence s_hw_held;
		hw_bus_req [*3];
	endsequence
	property p_rise; $rose(refresh_req) |-> $past(pause_active); endproperty
	a_rise: assert property (p_rise) else $error("refresh without pressure");
	property p_stop; pause_sent || !pause_active |=> !refresh_req; endproperty
	a_stop: assert property (p_stop) else $error("refresh not withdrawn");
	property p_len; !ext_area_enable |-> ext_area_len == 8'h00; endproperty
	a_len: assert property (p_len) else $error("length shown while area off");
	property p_ro; s_rd_ctrl |-> prdata[15:8] == 8'h00 && !prdata[4]; endproperty
	a_ro: assert property (p_ro) else $error("reserved control bits set");
	property p_hw; s_hw_held ##0 s_rd_ctrl |-> prdata[6]; endproperty
	a_hw: assert property (p_hw) else $error("bus request not reported");
	property p_ptr;
		s_rd_ctrl |-> prdata[27:16] == ext_area_ptr && prdata[0] == ext_area_enable;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer output differs");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_size;
		psel && penable && !pwrite && paddr == FRX_OFS_EXT_SIZE && ext_area_enable
			|-> prdata[31:16] == {8'h00, ext_area_len};
	endproperty
	a_size: assert property (p_size) else $error("length field differs");
endmodule

bind frx_regs frx_regs_properties u_props (.clk_sys, .rst, .psel, .penable, .pwrite,
	.paddr, .prdata, .pslverr, .pause_active, .pause_sent, .refresh_req, .hw_bus_req,
	.ext_area_enable, .ext_area_ptr, .ext_area_len);

// ### bench/flow_refresh_and_ext_config_regs_tb_top.sv
// Self-checking bench for the flow refresh and extended config register bank
`timescale 1ns/1ns
module flow_refresh_and_ext_config_regs_tb_top
	import frx_pkg::*;
;
	logic clk_sys, rst, pci_reset, sw_reset, psel, penable, pwrite, pready, pslverr, err;
	logic byte_tick, pause_active, pause_sent, refresh_req, nvm_ctrl_load, nvm_area_we;
	logic nvm_vendor_we, nvm_len_load, hw_bus_req, phy_cfg_pending, ext_area_enable;
	logic vendor_load_go, phy_cfg_go;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, phy_ctrl_bits, v;
	logic [11:0] ext_area_ptr;
	logic [7:0]  nvm_len, ext_area_len;
	logic [31:0] exp_q[$];
	int          fails, cmp_count, seed, g, h;

	frx_regs DUT (.clk_sys, .rst, .pci_reset, .sw_reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .byte_tick, .pause_active, .pause_sent,
		.refresh_req, .nvm_ctrl_load, .nvm_area_we, .nvm_vendor_we, .nvm_len_load, .nvm_len,
		.hw_bus_req, .phy_cfg_pending, .ext_area_enable, .ext_area_ptr, .ext_area_len,
		.vendor_load_go, .phy_cfg_go, .phy_ctrl_bits);

	// ********
	// Tasks
	// ********
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(int k);
		repeat (k) @(posedge clk_sys);
	endtask
	// Bus cycle held until pready; read notes go to the queue at setup
	task automatic apb(logic w, logic [19:0] a, logic [31:0] d, logic [31:0] e);
		int k;
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		if (!w) exp_q.push_back(e);
		@(posedge clk_sys);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 20);
		err = pslverr;
		if (k == 20) give_verdict();
		{psel, penable} <= 2'b00;
		@(posedge clk_sys);
	endtask
	// Counts go pulses over a fixed stretch; a single pulse would be missed by a level test
	task automatic watch();
		g = 0;
		h = 0;
		repeat (20) begin
			@(posedge clk_sys);
			g += vendor_load_go;
			h += phy_cfg_go;
		end
	endtask

	// Read monitor: oldest note against the data taken at the access edge
	always @(posedge clk_sys) begin
		if (psel && penable && pready && !pwrite) chk("read data", prdata, exp_q.pop_front());
	end

	initial begin
		clk_sys = 0;
		forever #25 clk_sys = ~clk_sys;
	end

	// ********
	// Sequence
	// ********
	initial begin
		{seed, fails, cmp_count} = {32'd27547, 64'd0};
		{pci_reset, sw_reset, psel, penable, pwrite, byte_tick, pause_active} = 0;
		{pause_sent, nvm_ctrl_load, nvm_area_we, nvm_vendor_we, nvm_len_load} = 0;
		{hw_bus_req, phy_cfg_pending, paddr, pwdata, nvm_len} = 0;
		rst = 1;
		cyc(5);
		rst <= 0;
		apb(0, FRX_OFS_EXT_CTRL, 0, 32'h0001_0008);
		apb(0, FRX_OFS_EXT_SIZE, 0, 0);
		apb(0, FRX_OFS_PHY_CTRL, 0, FRX_PHY_RESET);
		apb(0, FRX_OFS_REFRESH, 0, 0);
		apb(1, FRX_OFS_EXT_CTRL, '1, 0);
		apb(0, FRX_OFS_EXT_CTRL, 0, 32'hffff_00af);
		chk("area pointer", ext_area_ptr, 32'hfff);
		apb(1, FRX_OFS_EXT_SIZE, '1, 0);
		apb(0, FRX_OFS_EXT_SIZE, 0, 32'h00ff_ffff);
		apb(1, FRX_OFS_REFRESH, '1, 0);
		apb(0, FRX_OFS_REFRESH, 0, 32'h0000_ffff);
		v = $random(seed);
		apb(1, FRX_OFS_PHY_CTRL, v, 0);
		apb(0, FRX_OFS_PHY_CTRL, 0, v);
		chk("phy copy", phy_ctrl_bits, v);
		apb(0, 20'h00f04, 0, 0);
		chk("slave error", err, 1);
		// Both resets of the semaphore, one after the other
		for (int i = 1; i < 3; i++) begin
			apb(1, FRX_OFS_EXT_CTRL, '1, 0);
			{pci_reset, sw_reset} <= 2'(i);
			cyc(1);
			{pci_reset, sw_reset} <= 2'b00;
			apb(0, FRX_OFS_EXT_CTRL, 0, 32'hffff_008f);
		end
		phy_cfg_pending <= 1;
		watch();
		chk("gated actions", g + h, 0);
		apb(1, FRX_OFS_EXT_CTRL, 32'hffff_000f, 0);
		watch();
		chk("vendor load", g != 0 && h != 0, 1);
		apb(1, FRX_OFS_EXT_CTRL, 32'hffff_0001, 0);
		watch();
		chk("vendor off", g, 0);
		hw_bus_req <= 1;
		cyc(4);
		apb(0, FRX_OFS_EXT_CTRL, 0, 32'hffff_0041);
		{nvm_len_load, nvm_len} <= {1'b1, 8'($random(seed))};
		cyc(1);
		nvm_len_load <= 0;
		cyc(1);
		chk("area length", ext_area_len, nvm_len);
		{nvm_ctrl_load, nvm_area_we, nvm_vendor_we} <= 3'b101;
		{nvm_len_load, nvm_len} <= 9'h100;
		cyc(1);
		{nvm_ctrl_load, nvm_len_load} <= 2'b00;
		cyc(1);
		chk("length when off", ext_area_len, 0);
		apb(0, FRX_OFS_EXT_CTRL, 0, 32'hffff_0048);
		apb(1, FRX_OFS_REFRESH, 2, 0);
		{pause_active, byte_tick} <= 2'b11;
		g = 0;
		while (!refresh_req && g < 400) begin
			@(posedge clk_sys);
			g++;
		end
		chk("refresh delay", g >= 128 && g <= 131, 1);
		pause_sent <= 1;
		cyc(1);
		pause_sent <= 0;
		cyc(1);
		chk("after pause", refresh_req, 0);
		pause_active <= 0;
		cyc(200);
		chk("no pressure", refresh_req, 0);
		apb(1, FRX_OFS_REFRESH, 0, 0);
		pause_active <= 1;
		cyc(300);
		chk("zero threshold", refresh_req, 0);
		give_verdict();
	end
endmodule
